// ### bench/tcx_timer_crossing_asserts.sv
`timescale 1ns/1ns
module tcx_timer_crossing_chk (
    input wire logic                clock,
    input wire logic                nrst,
    input wire logic                avs_read,
    input wire logic                avs_write,
    input wire logic [31:0]         avs_readdata,
    input wire logic                avs_waitrequest,
    input wire logic                sleep_active,
    input wire tcx_pkg::tcx_sleep_t sleep_mode,
    input wire logic                oscillator_enable,
    input wire logic                crystal_pins_owned,
    input wire logic                wake_request,
    input wire logic                cpu_halt
);
    import tcx_pkg::*;
    // Power-down and standby are the only sleep modes that stop the crystal.
    wire deep_sleep = sleep_active && (sleep_mode == sleep_power_down || sleep_mode == sleep_standby);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    property p_req_answer; $rose(avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest; endproperty
    a_req_answer: assert property (p_req_answer) else $error("bus answer late");
    property p_rd_high; !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000; endproperty
    a_rd_high: assert property (p_rd_high) else $error("read upper bits set");
    property p_osc_deep; deep_sleep |=> !oscillator_enable; endproperty
    a_osc_deep: assert property (p_osc_deep) else $error("oscillator on in deep sleep");
    property p_osc_run; crystal_pins_owned && !sleep_active ##1 crystal_pins_owned |-> oscillator_enable; endproperty
    a_osc_run: assert property (p_osc_run) else $error("oscillator off while awake");
    property p_sync_idle; !crystal_pins_owned |-> !oscillator_enable; endproperty
    a_sync_idle: assert property (p_sync_idle) else $error("oscillator on in sync mode");
    property p_wake_pulse; wake_request |=> !wake_request; endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than one cycle");
    property p_wake_halt; wake_request |-> cpu_halt ##1 cpu_halt [*3] ##1 !cpu_halt; endproperty
    a_wake_halt: assert property (p_wake_halt) else $error("halt length wrong");
    property p_halt_cause; $rose(cpu_halt) |-> wake_request; endproperty
    a_halt_cause: assert property (p_halt_cause) else $error("halt without wake");
endmodule

bind tcx_timer_crossing tcx_timer_crossing_chk tcx_timer_crossing_chk_i (
    .clock(clock), .nrst(nrst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sleep_active(sleep_active),
    .sleep_mode(sleep_mode), .oscillator_enable(oscillator_enable),
    .crystal_pins_owned(crystal_pins_owned), .wake_request(wake_request), .cpu_halt(cpu_halt)
);

// ### bench/tcx_xtal_model.sv
`timescale 1ns/1ns
// Watch crystal at the pin; it stands still at its last level whenever the oscillator is off.
module tcx_xtal_model #(
    parameter int HALF = 6
) (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic run,
    output logic      crystal_in_pin
);
    int cnt;

    // A half period of several processor cycles keeps the processor clock far above four times the crystal.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt <= 0;
            crystal_in_pin <= 1'h0;
        end
        else if (run)
        begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1)
            begin
                crystal_in_pin <= !crystal_in_pin;
            end
        end
    end
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ns
`include "tcx_defs.svh"
module testbench;
    import tcx_pkg::*;
    logic        clock = 0, nrst = 0, avs_read = 0, avs_write = 0, sleep_active = 0, deep_wake = 0;
    logic [4:0]  avs_address = 0;
    logic [31:0] avs_writedata = 0;
    tcx_sleep_t  sleep_mode = sleep_idle;
    wire  [31:0] avs_readdata;
    wire         avs_waitrequest, crystal_in_pin, crystal_pins_owned, oscillator_enable, irq_request, wake_request;
    wire         cpu_halt, compare_output_pin;
    int          err_total = 0, check_count = 0, cyc = 0, t0;
    logic [7:0]  q;

    // Free-running clock and a cycle count for timing checks.
    initial forever #20 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;

    tcx_timer_crossing tcx_timer_crossing_i (.clock(clock), .nrst(nrst), .ce(1'h1), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .crystal_in_pin(crystal_in_pin),
        .sleep_active(sleep_active), .sleep_mode(sleep_mode), .deep_wake(deep_wake),
        .compare_output_pin(compare_output_pin),
        .crystal_pins_owned(crystal_pins_owned), .oscillator_enable(oscillator_enable),
        .irq_request(irq_request), .wake_request(wake_request), .cpu_halt(cpu_halt));
    tcx_xtal_model tcx_xtal_model_i (.clock(clock), .nrst(nrst), .run(oscillator_enable), .crystal_in_pin(crystal_in_pin));

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task close_out;
        if (err_total == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // One bus access; the request stands until a rising edge samples waitrequest low, and read data is taken there.
    task acc(input logic w, input logic [4:0] a, input logic [7:0] d);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h00_0000, d};
        @(posedge clock);
        while (avs_waitrequest !== 1'h0)
            @(posedge clock);
        q = avs_readdata[7:0];
        avs_read <= 0;
        avs_write <= 0;
        repeat (3) @(posedge clock);
    endtask

    task rd(input logic [4:0] a, input logic [7:0] exp);
        acc(0, a, 8'h00);
        chk(q, exp);
    endtask

    // Polls status until no transfer is pending; the watchdog ends a hang.
    task idle;
        acc(0, `TCX_OFS_STATUS, 8'h00);
        while ((q & 8'h07) != 8'h00)
            acc(0, `TCX_OFS_STATUS, 8'h00);
    endtask

    // Main sequence: reset values, clock selects, overflow, wake, async transfers, deep sleep.
    initial
    begin
        repeat (16) @(posedge clock);
        nrst <= 1;
        @(posedge clock);
        for (int a = 0; a < 32; a += 4) rd(a[4:0], 8'h00);
        chk({7'h00, crystal_pins_owned}, 8'h00);
        for (int c = 0; c < 8; c++)
        begin
            acc(1, `TCX_OFS_CONTROL, c[7:0]);
            rd(`TCX_OFS_CONTROL, c[7:0]);
        end
        acc(1, `TCX_OFS_CONTROL, 8'h00);
        acc(1, `TCX_OFS_COMPARE, 8'hff);
        acc(1, `TCX_OFS_COUNTER, 8'hfe);
        acc(1, `TCX_OFS_ENABLES, 8'h01);
        acc(1, `TCX_OFS_CONTROL, 8'h11);
        rd(`TCX_OFS_FLAGS, 8'h03);
        chk({7'h00, irq_request}, 8'h01);
        chk({7'h00, compare_output_pin}, 8'h01);
        acc(1, `TCX_OFS_CONTROL, 8'h00);
        acc(1, `TCX_OFS_COUNTER, 8'hfe);
        acc(1, `TCX_OFS_FLAGS, 8'h03);
        rd(`TCX_OFS_FLAGS, 8'h00);
        sleep_mode <= sleep_power_save;
        sleep_active <= 1;
        acc(1, `TCX_OFS_CONTROL, 8'h01);
        t0 = 0;
        while (wake_request !== 1'h1 && t0 < 300)
        begin
            t0++;
            @(negedge clock);
        end
        chk({7'h00, cpu_halt}, 8'h01);
        @(posedge clock);
        sleep_active <= 0;
        repeat (4) @(negedge clock);
        chk({7'h00, cpu_halt}, 8'h00);
        @(posedge clock);
        acc(1, `TCX_OFS_CONTROL, 8'h00);
        acc(1, `TCX_OFS_ENABLES, 8'h00);
        acc(1, `TCX_OFS_STATUS, 8'h08);
        chk({7'h00, crystal_pins_owned}, 8'h01);
        t0 = cyc;
        acc(1, `TCX_OFS_COMPARE, 8'h5a);
        rd(`TCX_OFS_STATUS, 8'h0a);
        acc(1, `TCX_OFS_COUNTER, 8'h10);
        rd(`TCX_OFS_STATUS, 8'h0e);
        idle;
        chk({7'h00, cyc - t0 >= 12 && cyc - t0 <= 60}, 8'h01);
        rd(`TCX_OFS_COMPARE, 8'h5a);
        rd(`TCX_OFS_COUNTER, 8'h10);
        sleep_mode <= sleep_power_down;
        sleep_active <= 1;
        repeat (2) @(negedge clock);
        chk({7'h00, oscillator_enable}, 8'h00);
        @(posedge clock);
        deep_wake <= 1;
        sleep_active <= 0;
        @(posedge clock);
        deep_wake <= 0;
        rd(`TCX_OFS_STATUS, 8'h18);
        acc(1, `TCX_OFS_STATUS, 8'h18);
        rd(`TCX_OFS_STATUS, 8'h08);
        acc(1, `TCX_OFS_SPECIAL, 8'h01);
        rd(`TCX_OFS_SPECIAL, 8'h00);
        close_out;
    end

    // A hang ends the run as a failure.
    initial
    begin
        #(40 * 20000);
        err_total++;
        close_out;
    end
endmodule

// ### hw/tcx_defs.svh
`ifndef TCX_DEFS_SVH
`define TCX_DEFS_SVH

// Register byte offsets on the Avalon-MM slave.
`define TCX_OFS_COUNTER   5'h00
`define TCX_OFS_COMPARE   5'h04
`define TCX_OFS_CONTROL   5'h08
`define TCX_OFS_STATUS    5'h0c
`define TCX_OFS_FLAGS     5'h10
`define TCX_OFS_ENABLES   5'h14
`define TCX_OFS_SPECIAL   5'h18

// Status register bit positions.
`define TCX_ST_CTRL_BUSY  0
`define TCX_ST_CMP_BUSY   1
`define TCX_ST_CNT_BUSY   2
`define TCX_ST_ASYNC      3
`define TCX_ST_LOST       4

// Flag and enable bit positions.
`define TCX_FL_OVF        0
`define TCX_FL_CMP        1

// Control register fields.
`define TCX_CT_CS_MSB     2
`define TCX_CT_CS_LSB     0
`define TCX_CT_TOGGLE     4

// Special function register bit positions.
`define TCX_SF_PSCLR      0

// Clock select codes.
`define TCX_CS_STOP       3'h0
`define TCX_CS_DIV1       3'h1
`define TCX_CS_DIV8       3'h2
`define TCX_CS_DIV32      3'h3
`define TCX_CS_DIV64      3'h4
`define TCX_CS_DIV128     3'h5
`define TCX_CS_DIV256     3'h6
`define TCX_CS_DIV1024    3'h7

// Reset values and timing counts.
`define TCX_RST_BYTE      8'h00
`define TCX_XTAL_EDGES    2
`define TCX_FLAG_STAGES   3
`define TCX_HALT_CYCLES   3'h4

`endif

// ### hw/tcx_hold_unit.sv
`timescale 1ns/1ns
`include "tcx_defs.svh"

module tcx_hold_unit #(
    parameter int WIDTH = 8,
    parameter int EDGES = `TCX_XTAL_EDGES
) (
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic             ce,
    input  wire logic             async_mode,
    input  wire logic             write_strobe,
    input  wire logic [WIDTH-1:0] write_data,
    input  wire logic             xtal_tick,
    output logic      [WIDTH-1:0] held_value,
    output logic                  load_pulse,
    output logic                  busy
);
    import tcx_pkg::*;

    logic       pending;
    logic [1:0] edge_count;
    logic       done_s1;
    logic       done_s2;

    // The last crystal edge of a pending transfer, and an immediate load in synchronous mode.
    wire async_write = write_strobe & async_mode;
    wire sync_load   = write_strobe & ~async_mode;
    wire edge_last   = pending & xtal_tick & (edge_count == 2'(EDGES - 1));

    // The value waits here so that other registers' writes cannot disturb it.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            held_value <= '0;
            load_pulse <= 1'b0;
        end
        else if (ce)
        begin
            if (write_strobe)
                held_value <= write_data; // R01 R02
            load_pulse <= sync_load | edge_last; // R01
        end
    end

    // Count crystal edges; a fresh write restarts the count from zero.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            pending    <= 1'b0;
            edge_count <= 2'h0;
        end
        else if (ce)
        begin
            if (async_write)
            begin
                pending    <= 1'b1;
                edge_count <= 2'h0;
            end
            else if (pending & xtal_tick)
            begin
                edge_count <= edge_count + 2'h1; // R01
                if (edge_last)
                    pending <= 1'b0;
            end
        end
    end

    // The completion passes two stages before it clears busy; a new write wins over the clear.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
            busy    <= 1'b0;
        end
        else if (ce)
        begin
            done_s1 <= edge_last; // R23
            done_s2 <= done_s1; // R23
            if (async_write)
                busy <= 1'b1; // R22
            else if (done_s2)
                busy <= 1'b0; // R22 R03
        end
    end

endmodule

// ### hw/tcx_pkg.sv
package tcx_pkg;

    // Sleep modes reported by the power manager.
    typedef enum logic [2:0] {
        sleep_idle,
        sleep_adc_noise,
        sleep_power_save,
        sleep_power_down,
        sleep_standby,
        sleep_ext_standby
    } tcx_sleep_t;

endpackage

// ### hw/tcx_timer_crossing.sv
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "tcx_defs.svh"

// Overview of operation
// R01: Counter, compare and control writes are held, then loaded after two crystal edges.
// R02: Each of the three registers owns its own holding register.
// R03: A status register shows whether each held transfer has finished.
// R04: Software must not rewrite a register while its transfer is pending.
// R05: Compare matching is blocked while counter or compare writes are in flight.
// R06: Software follows a fixed sequence when switching the timer clock source.
// R07: Processor clock must exceed four times the crystal frequency.
// R08: Wake logic needs one crystal cycle to rearm; earlier sleep gets no wake.
// R09: Software waits for busy to clear before entering power-save sleep.
// R10: In asynchronous mode the oscillator runs except in power-down and standby.
// R11: Timer contents are considered lost after waking from power-down or standby.
// R12: Software waits one second for the oscillator after power-up or deep wake.
// R13: Wake-up starts on the timer clock cycle after the interrupt condition.
// R14: After a timer wake the processor stays halted four cycles.
// R15: Counter reads use a copy refreshed on every rising crystal edge.
// R16: Software writes compare or control and waits for busy before reading count.
// R17: Asynchronous flag synchronisation takes three processor cycles plus one timer cycle.
// R18: The compare output pin changes on the timer clock, unsynchronised.
// R19: Timer clock defaults to I/O clock; async select takes over crystal pins.
// R20: Prescaler offers divide by 1, 8, 32, 64, 128, 256, 1024 or stop.
// R21: Prescaler clear bit resets the prescaler count for a known phase.
// R22: Busy flags set on asynchronous writes and clear once the destination loads.
// R23: Busy clears reach the I/O domain through a two-stage synchroniser.

module tcx_timer_crossing #(
    parameter int ADDR_W = 5
) (
    input  wire logic              clock,
    input  wire logic              nrst,
    input  wire logic              ce,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              crystal_in_pin,
    input  wire logic              sleep_active,
    input  wire tcx_pkg::tcx_sleep_t sleep_mode,
    input  wire logic              deep_wake,
    output logic                   compare_output_pin,
    output logic                   crystal_pins_owned,
    output logic                   oscillator_enable,
    output logic                   irq_request,
    output logic                   wake_request,
    output logic                   cpu_halt
);
    import tcx_pkg::*;

    logic       xtal_s1;
    logic       xtal_s2;
    logic       xtal_s3;
    logic       xtal_level;
    logic       async_clock_select;
    logic       state_lost;
    logic [7:0] counter_value;
    logic [7:0] counter_copy;
    logic [7:0] compare_value;
    logic [7:0] timer_control;
    logic [9:0] pre_count;
    logic       count_block;
    logic [1:0] flags;
    logic [1:0] enables;
    logic [`TCX_FLAG_STAGES-1:0] ovf_pipe;
    logic [`TCX_FLAG_STAGES-1:0] cmp_pipe;
    logic       wake_pending;
    logic       wake_armed;
    logic [2:0] halt_count;
    logic [7:0] cnt_held;
    logic [7:0] cmp_held;
    logic [7:0] ctl_held;
    logic       cnt_load;
    logic       cmp_load;
    logic       ctl_load;
    logic       counter_update_pending;
    logic       compare_update_pending;
    logic       control_update_pending;

    // Bus writes happen on the edge where waitrequest is already low.
    wire bus_req    = avs_read | avs_write;
    wire bus_take   = bus_req & ~avs_waitrequest;
    wire bus_wr     = bus_take & avs_write & avs_byteenable[0];
    wire [7:0] wbyte = avs_writedata[7:0];
    wire sel_cnt    = avs_address == `TCX_OFS_COUNTER;
    wire sel_cmp    = avs_address == `TCX_OFS_COMPARE;
    wire sel_ctl    = avs_address == `TCX_OFS_CONTROL;
    wire sel_st     = avs_address == `TCX_OFS_STATUS;
    wire sel_fl     = avs_address == `TCX_OFS_FLAGS;
    wire sel_en     = avs_address == `TCX_OFS_ENABLES;
    wire sel_sf     = avs_address == `TCX_OFS_SPECIAL;
    wire wr_cnt     = bus_wr & sel_cnt;
    wire wr_cmp     = bus_wr & sel_cmp;
    wire wr_ctl     = bus_wr & sel_ctl;
    wire wr_st      = bus_wr & sel_st;
    wire wr_fl      = bus_wr & sel_fl;
    wire wr_en      = bus_wr & sel_en;
    wire psc_clear  = bus_wr & sel_sf & wbyte[`TCX_SF_PSCLR];

    // Status byte; the busy bits are read-only and the lost bit reads its marker, cleared by writing one.
    wire [7:0] status_byte = {3'h0, state_lost, async_clock_select,
                              counter_update_pending, compare_update_pending, control_update_pending}; // R03

    // Read selection; unmapped offsets read as zero.
    wire [7:0] read_byte = sel_cnt ? counter_copy : // R15
                           sel_cmp ? compare_value :
                           sel_ctl ? timer_control :
                           sel_st  ? status_byte :
                           sel_fl  ? {6'h00, flags} :
                           sel_en  ? {6'h00, enables} :
                           8'h00;

    // A crystal rise counts only once the second and third stages agree.
    wire xtal_rise = xtal_s2 & xtal_s3 & ~xtal_level;

    // The timer source clock is the I/O clock unless the crystal is selected.
    wire timer_source_clock = async_clock_select ? xtal_rise : 1'b1; // R19

    // Divided ticks taken from the shared prescaler count.
    wire [2:0] clk_sel   = timer_control[`TCX_CT_CS_MSB:`TCX_CT_CS_LSB];
    wire tick_8    = timer_source_clock & (&pre_count[2:0]);
    wire tick_32   = timer_source_clock & (&pre_count[4:0]);
    wire tick_64   = timer_source_clock & (&pre_count[5:0]);
    wire tick_128  = timer_source_clock & (&pre_count[6:0]);
    wire tick_256  = timer_source_clock & (&pre_count[7:0]);
    wire tick_1024 = timer_source_clock & (&pre_count[9:0]);
    wire count_tick = (clk_sel == `TCX_CS_DIV1)    ? timer_source_clock :
                      (clk_sel == `TCX_CS_DIV8)    ? tick_8 :
                      (clk_sel == `TCX_CS_DIV32)   ? tick_32 :
                      (clk_sel == `TCX_CS_DIV64)   ? tick_64 :
                      (clk_sel == `TCX_CS_DIV128)  ? tick_128 :
                      (clk_sel == `TCX_CS_DIV256)  ? tick_256 :
                      (clk_sel == `TCX_CS_DIV1024) ? tick_1024 :
                      1'b0; // R20

    // Matching waits until both the counter and compare values have settled.
    wire match_block = counter_update_pending | compare_update_pending | count_block; // R05
    wire ovf_event   = count_tick & ~cnt_load & (counter_value == 8'hff);
    wire cmp_event   = count_tick & ~cnt_load & ~match_block & (counter_value == compare_value);

    // In asynchronous mode the flag events cross a three-stage delay after the timer tick.
    wire ovf_set = async_clock_select ? ovf_pipe[`TCX_FLAG_STAGES-1] : ovf_event; // R17
    wire cmp_set = async_clock_select ? cmp_pipe[`TCX_FLAG_STAGES-1] : cmp_event; // R17
    wire [1:0] flag_set = {cmp_set, ovf_set};
    wire [1:0] flag_clr = wr_fl ? wbyte[1:0] : 2'h0;

    // Sleep decoding for oscillator control and wake-up.
    wire save_sleep = sleep_active & (sleep_mode == sleep_power_save || sleep_mode == sleep_ext_standby);
    wire deep_sleep = sleep_active & (sleep_mode == sleep_power_down || sleep_mode == sleep_standby);
    wire irq_cond   = |(flags & enables);
    wire wake_fire  = wake_pending & timer_source_clock; // R13

    // Three-stage sampling of the crystal pin; only the second stage reads the first.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            xtal_s1    <= 1'b0;
            xtal_s2    <= 1'b0;
            xtal_s3    <= 1'b0;
            xtal_level <= 1'b0;
        end
        else if (ce)
        begin
            xtal_s1 <= crystal_in_pin;
            xtal_s2 <= xtal_s1;
            xtal_s3 <= xtal_s2;
            if (xtal_s2 == xtal_s3)
                xtal_level <= xtal_s3;
        end
    end

    // One holding unit per destination so pending transfers stay independent.
    tcx_hold_unit #(.WIDTH(8)) u_hold_cnt (
        .clock        (clock),
        .nrst         (nrst),
        .ce           (ce),
        .async_mode   (async_clock_select),
        .write_strobe (wr_cnt),
        .write_data   (wbyte),
        .xtal_tick    (xtal_rise),
        .held_value   (cnt_held),
        .load_pulse   (cnt_load),
        .busy         (counter_update_pending)
    ); // R02

    tcx_hold_unit #(.WIDTH(8)) u_hold_cmp (
        .clock        (clock),
        .nrst         (nrst),
        .ce           (ce),
        .async_mode   (async_clock_select),
        .write_strobe (wr_cmp),
        .write_data   (wbyte),
        .xtal_tick    (xtal_rise),
        .held_value   (cmp_held),
        .load_pulse   (cmp_load),
        .busy         (compare_update_pending)
    ); // R02

    tcx_hold_unit #(.WIDTH(8)) u_hold_ctl (
        .clock        (clock),
        .nrst         (nrst),
        .ce           (ce),
        .async_mode   (async_clock_select),
        .write_strobe (wr_ctl),
        .write_data   (wbyte),
        .xtal_tick    (xtal_rise),
        .held_value   (ctl_held),
        .load_pulse   (ctl_load),
        .busy         (control_update_pending)
    ); // R02

    // Avalon slave: one wait cycle, read data captured as waitrequest falls.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end
        else if (ce)
        begin
            avs_waitrequest <= ~(bus_req & avs_waitrequest);
            if (avs_read & avs_waitrequest)
                avs_readdata <= {24'h00_0000, read_byte};
        end
    end

    // Destination registers load only from their holding units.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            counter_value <= `TCX_RST_BYTE;
            compare_value <= `TCX_RST_BYTE;
            timer_control <= `TCX_RST_BYTE;
            count_block   <= 1'b0;
        end
        else if (ce)
        begin
            if (cnt_load)
                counter_value <= cnt_held; // R01
            else if (count_tick)
                counter_value <= counter_value + 8'h01;
            if (cmp_load)
                compare_value <= cmp_held; // R01
            if (ctl_load)
                timer_control <= ctl_held; // R01
            // A counter load suppresses the match on the following timer tick.
            if (cnt_load)
                count_block <= 1'b1; // R05
            else if (count_tick)
                count_block <= 1'b0;
        end
    end

    // The read copy follows the counter on each crystal rise, or every cycle when synchronous.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            counter_copy <= `TCX_RST_BYTE;
        else if (ce && (xtal_rise || !async_clock_select))
            counter_copy <= counter_value; // R15
    end

    // Prescaler count; the clear strobe restarts the phase.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            pre_count <= 10'h000;
        else if (ce)
        begin
            if (psc_clear)
                pre_count <= 10'h000; // R21
            else if (timer_source_clock)
                pre_count <= pre_count + 10'h001; // R20
        end
    end

    // Clock select, lost-state marker and the direct bus registers.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            async_clock_select <= 1'b0;
            state_lost         <= 1'b0;
            enables            <= 2'h0;
        end
        else if (ce)
        begin
            if (wr_st)
                async_clock_select <= wbyte[`TCX_ST_ASYNC]; // R19
            // A deep wake wins over a clear in the same cycle.
            if (deep_wake)
                state_lost <= 1'b1; // R11
            else if (wr_st && wbyte[`TCX_ST_LOST])
                state_lost <= 1'b0;
            if (wr_en)
                enables <= wbyte[1:0];
        end
    end

    // Flag delay lines and sticky flags; a set beats a software clear.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            ovf_pipe <= '0;
            cmp_pipe <= '0;
            flags    <= 2'h0;
        end
        else if (ce)
        begin
            ovf_pipe <= {ovf_pipe[`TCX_FLAG_STAGES-2:0], ovf_event}; // R17
            cmp_pipe <= {cmp_pipe[`TCX_FLAG_STAGES-2:0], cmp_event}; // R17
            flags    <= (flags & ~flag_clr) | flag_set;
        end
    end

    // Compare output toggles straight on the timer tick with no I/O-domain stage.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            compare_output_pin <= 1'b0;
        else if (ce && cmp_event && timer_control[`TCX_CT_TOGGLE])
            compare_output_pin <= ~compare_output_pin; // R18
    end

    // Pin ownership, oscillator gating and the interrupt request.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            crystal_pins_owned <= 1'b0;
            oscillator_enable  <= 1'b0;
            irq_request        <= 1'b0;
        end
        else if (ce)
        begin
            crystal_pins_owned <= async_clock_select; // R19
            oscillator_enable  <= async_clock_select & ~deep_sleep; // R10
            irq_request        <= irq_cond;
        end
    end

    // Wake sequencing; rearming waits one timer clock so a hasty re-sleep gets no wake.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            wake_pending <= 1'b0;
            wake_armed   <= 1'b1;
            wake_request <= 1'b0;
        end
        else if (ce)
        begin
            wake_request <= wake_fire; // R13
            if (wake_fire)
            begin
                wake_pending <= 1'b0;
                wake_armed   <= 1'b0; // R08
            end
            else
            begin
                if (irq_cond && save_sleep && wake_armed)
                    wake_pending <= 1'b1; // R13
                if (!wake_armed && timer_source_clock)
                    wake_armed <= 1'b1; // R08
            end
        end
    end

    // Processor halt window after a timer wake.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            halt_count <= 3'h0;
            cpu_halt   <= 1'b0;
        end
        else if (ce)
        begin
            if (wake_fire)
                halt_count <= `TCX_HALT_CYCLES; // R14
            else if (halt_count != 3'h0)
                halt_count <= halt_count - 3'h1;
            cpu_halt <= wake_fire | (halt_count > 3'h1); // R14
        end
    end

endmodule
